// ===== rtl/ptpts_pkg.sv
package ptpts_pkg;

    // *****************************************
    // register offsets inside the port window
    // *****************************************
    localparam logic [11:0] PTPTS_OFS_ASYM      = 12'hc04;
    localparam logic [11:0] PTPTS_OFS_REQ_HI    = 12'hc08;
    localparam logic [11:0] PTPTS_OFS_REQ_LO    = 12'hc0a;
    localparam logic [11:0] PTPTS_OFS_SYNC_HI   = 12'hc0c;
    localparam logic [11:0] PTPTS_OFS_SYNC_LO   = 12'hc0e;
    localparam logic [11:0] PTPTS_OFS_RESP_HI   = 12'hc10;
    localparam logic [11:0] PTPTS_OFS_RESP_LO   = 12'hc12;
    localparam logic [11:0] PTPTS_OFS_STATUS    = 12'hc14;
    localparam logic [11:0] PTPTS_OFS_ENABLE    = 12'hc16;

    // *****************************************
    // field positions and reset values
    // *****************************************
    localparam int unsigned PTPTS_BIT_SIGN      = 15;
    localparam int unsigned PTPTS_MAG_W         = 15;
    localparam int unsigned PTPTS_BIT_SYNC      = 15;
    localparam int unsigned PTPTS_BIT_REQ       = 14;
    localparam int unsigned PTPTS_BIT_RESP      = 13;
    localparam int unsigned PTPTS_CORR_FRAC     = 16;
    localparam logic [15:0] PTPTS_RST_ASYM      = 16'h0000;
    localparam logic [31:0] PTPTS_RST_STAMP     = 32'h0000_0000;
    localparam logic [2:0]  PTPTS_RST_FLAGS     = 3'h0;

    // *****************************************
    // message kinds and carriers
    // *****************************************
    typedef enum logic [1:0] {
        PTPTS_MSG_SYNC,
        PTPTS_MSG_REQ,
        PTPTS_MSG_RESP,
        PTPTS_MSG_OTHER
    } ptpts_msg_e;

    typedef struct packed {
        logic        valid;
        ptpts_msg_e  kind;
        logic [31:0] ns;
    } ptpts_stamp_s;

    typedef struct packed {
        logic        valid;
        logic        egress;
        ptpts_msg_e  kind;
        logic [63:0] field;
    } ptpts_corr_s;

endpackage

// ===== rtl/ptpts_corr_adj.sv
module ptpts_corr_adj
    import ptpts_pkg::*;
(
    // asymmetry setting
    input  wire logic                   asym_sign,
    input  wire logic [PTPTS_MAG_W-1:0] asym_magnitude,
    // correction field in and out
    input  wire ptpts_corr_s            corr_in,
    output logic [63:0]                 corr_adj
);

    // *****************************************
    // signed asymmetry in correction units
    // *****************************************
    // correction field carries ns scaled by 2^16
    wire logic [63:0] mag_scaled;
    wire logic [63:0] delta;
    wire logic        do_add;
    wire logic        do_sub;

    assign mag_scaled = {{(64-PTPTS_MAG_W-PTPTS_CORR_FRAC){1'b0}}, asym_magnitude,
                         {PTPTS_CORR_FRAC{1'b0}}};
    assign delta      = asym_sign ? (64'h0 - mag_scaled) : mag_scaled; // [R1]

    // ingress sync and peer response add, egress requests subtract
    assign do_add = !corr_in.egress &&
                    (corr_in.kind == PTPTS_MSG_SYNC || corr_in.kind == PTPTS_MSG_RESP); // [R2]
    assign do_sub = corr_in.egress && (corr_in.kind == PTPTS_MSG_REQ);               // [R3]

    // other messages pass unchanged
    assign corr_adj = do_add ? (corr_in.field + delta) :
                      do_sub ? (corr_in.field - delta) : corr_in.field;

endmodule

// ===== rtl/ptpts_port_regs.sv
// Functional notes
// (R1) Asymmetry bit 15 is a read/write sign, 1 negative and 0 positive, reset zero.
// (R2) Asymmetry bits 14:0 are a magnitude in ns added to ingress Sync and Pdelay_Resp.
// (R3) The signed asymmetry is subtracted for egress Delay_Req and Pdelay_Req.
// (R4) A request egress time is caught as a read-only high and low word pair.
// (R5) A Sync egress time is caught in its own read-only pair that resets to zero.
// (R6) A Pdelay_Resp egress time is caught in its own read-only pair.
// (R7) Status bit 15 sets on a Sync stamp and clears by writing one.
// (R8) Status bit 14 sets on a request stamp and clears by writing one.
// (R9) Status bit 13 sets on a Pdelay_Resp stamp and clears by writing one.
// (R10) All status bits are ORed into the port stamp interrupt status.
// (R11) Enable bits 15, 14, 13 gate Sync, request, response interrupts; read/write, reset zero.
// (R12) The three enable bits are ORed into the port stamp interrupt enable.
// (R13) Reserved bits 12:0 of status and enable read zero and ignore writes.
module ptpts_port_regs
    import ptpts_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // management register port
    input  wire logic [11:0]  reg_addr,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    input  wire logic [1:0]   reg_be,
    input  wire logic [15:0]  reg_wdata,
    output logic [15:0]       reg_rdata,
    output logic              reg_ack,
    // egress stamp from the timestamp engine
    input  wire ptpts_stamp_s stamp_in,
    // correction field path
    input  wire ptpts_corr_s  corr_in,
    output logic [63:0]       corr_out,
    output logic              corr_out_valid,
    // port level interrupt bits
    output logic              port_stamp_irq_status,
    output logic              port_stamp_irq_enable,
    // asymmetry setting towards the datapath
    output logic              asym_sign,
    output logic [14:0]       asym_magnitude
);

    // *****************************************
    // helpers
    // *****************************************
    // byte lane merge: lane 1 is bits 15:8, lane 0 bits 7:0
    function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                               input logic [15:0] new_v,
                                               input logic [1:0]  be);
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction

    // flag vector at bits 15:13 of a register image, any mix of the three may be set
    function automatic logic [15:0] flags_to_word(input logic [2:0] f);
        logic [15:0] w;
        w = 16'h0000;
        w[PTPTS_BIT_SYNC] = f[2];
        w[PTPTS_BIT_REQ]  = f[1];
        w[PTPTS_BIT_RESP] = f[0];
        return w;
    endfunction

    // pick bits 15:13 back out of a written word
    function automatic logic [2:0] word_to_flags(input logic [15:0] w);
        return {w[PTPTS_BIT_SYNC], w[PTPTS_BIT_REQ], w[PTPTS_BIT_RESP]};
    endfunction

    // *****************************************
    // state
    // *****************************************
    logic [15:0] asym_r;
    logic [15:0] asym_nxt;
    logic [31:0] req_stamp_r;
    logic [31:0] req_stamp_nxt;
    logic [31:0] sync_stamp_r;
    logic [31:0] sync_stamp_nxt;
    logic [31:0] resp_stamp_r;
    logic [31:0] resp_stamp_nxt;
    logic [2:0]  pending_r;
    logic [2:0]  pending_nxt;
    logic [2:0]  irq_on_r;
    logic [2:0]  irq_on_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic        ack_r;
    logic [63:0] corr_r;
    logic        corr_valid_r;
    logic        irq_status_r;
    logic        irq_enable_r;

    // *****************************************
    // address decode
    // *****************************************
    wire logic hit_asym;
    wire logic hit_req_hi;
    wire logic hit_req_lo;
    wire logic hit_sync_hi;
    wire logic hit_sync_lo;
    wire logic hit_resp_hi;
    wire logic hit_resp_lo;
    wire logic hit_status;
    wire logic hit_enable;
    wire logic wr_any;

    // byte address bit 0 ignored, registers are 16-bit aligned
    assign hit_asym    = reg_addr[11:1] == PTPTS_OFS_ASYM[11:1];
    assign hit_req_hi  = reg_addr[11:1] == PTPTS_OFS_REQ_HI[11:1];
    assign hit_req_lo  = reg_addr[11:1] == PTPTS_OFS_REQ_LO[11:1];
    assign hit_sync_hi = reg_addr[11:1] == PTPTS_OFS_SYNC_HI[11:1];
    assign hit_sync_lo = reg_addr[11:1] == PTPTS_OFS_SYNC_LO[11:1];
    assign hit_resp_hi = reg_addr[11:1] == PTPTS_OFS_RESP_HI[11:1];
    assign hit_resp_lo = reg_addr[11:1] == PTPTS_OFS_RESP_LO[11:1];
    assign hit_status  = reg_addr[11:1] == PTPTS_OFS_STATUS[11:1];
    assign hit_enable  = reg_addr[11:1] == PTPTS_OFS_ENABLE[11:1];
    assign wr_any      = reg_wr && !reg_rd;

    // *****************************************
    // asymmetry register
    // *****************************************
    // sign and magnitude written together or per byte lane
    assign asym_nxt = (wr_any && hit_asym) ? lane_merge(asym_r, reg_wdata, reg_be)
                                           : asym_r; // [R1] [R2]

    // *****************************************
    // egress stamp capture
    // *****************************************
    // a new stamp overwrites the old one even if software has not read it;
    // the pending flag only shows that a stamp arrived, never that one was missed
    wire logic cap_sync;
    wire logic cap_req;
    wire logic cap_resp;

    assign cap_sync = stamp_in.valid && (stamp_in.kind == PTPTS_MSG_SYNC);
    assign cap_req  = stamp_in.valid && (stamp_in.kind == PTPTS_MSG_REQ);
    assign cap_resp = stamp_in.valid && (stamp_in.kind == PTPTS_MSG_RESP);

    assign req_stamp_nxt  = cap_req  ? stamp_in.ns : req_stamp_r;  // [R4]
    assign sync_stamp_nxt = cap_sync ? stamp_in.ns : sync_stamp_r; // [R5]
    assign resp_stamp_nxt = cap_resp ? stamp_in.ns : resp_stamp_r; // [R6]

    // *****************************************
    // pending flags, write one to clear
    // *****************************************
    wire logic [2:0] set_vec;
    wire logic [2:0] clr_vec;
    wire logic [15:0] clr_word;

    assign set_vec  = {cap_sync, cap_req, cap_resp};
    // only bits 15:13 are looked at, reserved bits drop out here
    assign clr_word = (wr_any && hit_status) ? lane_merge(16'h0000, reg_wdata, reg_be)
                                             : 16'h0000; // [R13]
    assign clr_vec  = word_to_flags(clr_word);
    // a stamp arriving with the clear keeps its flag set
    assign pending_nxt = (pending_r & ~clr_vec) | set_vec; // [R7] [R8] [R9]

    // *****************************************
    // interrupt enables
    // *****************************************
    assign irq_on_nxt = (wr_any && hit_enable)
                      ? word_to_flags(lane_merge(flags_to_word(irq_on_r), reg_wdata, reg_be))
                      : irq_on_r; // [R11] [R13]

    // *****************************************
    // read mux
    // *****************************************
    wire logic [15:0] rd_word;

    assign rd_word = hit_asym    ? asym_r               :
                     hit_req_hi  ? req_stamp_r[31:16]   :
                     hit_req_lo  ? req_stamp_r[15:0]    :
                     hit_sync_hi ? sync_stamp_r[31:16]  :
                     hit_sync_lo ? sync_stamp_r[15:0]   :
                     hit_resp_hi ? resp_stamp_r[31:16]  :
                     hit_resp_lo ? resp_stamp_r[15:0]   :
                     hit_status  ? flags_to_word(pending_r) : // [R13]
                     hit_enable  ? flags_to_word(irq_on_r)  :
                                   16'h0000;
    // data held between reads so a slow master can sample late
    assign rdata_nxt = reg_rd ? rd_word : rdata_r;

    // *****************************************
    // correction adjust
    // *****************************************
    wire logic [63:0] corr_adj;

    ptpts_corr_adj u_corr_adj (
        .asym_sign      (asym_r[PTPTS_BIT_SIGN]),
        .asym_magnitude (asym_r[PTPTS_MAG_W-1:0]),
        .corr_in        (corr_in),
        .corr_adj       (corr_adj)
    );

    // *****************************************
    // register update
    // *****************************************
    // configuration and captures
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            asym_r       <= PTPTS_RST_ASYM;
            req_stamp_r  <= PTPTS_RST_STAMP;
            sync_stamp_r <= PTPTS_RST_STAMP;
            resp_stamp_r <= PTPTS_RST_STAMP;
            pending_r    <= PTPTS_RST_FLAGS;
            irq_on_r     <= PTPTS_RST_FLAGS;
        end else begin
            asym_r       <= asym_nxt;
            req_stamp_r  <= req_stamp_nxt;
            sync_stamp_r <= sync_stamp_nxt;
            resp_stamp_r <= resp_stamp_nxt;
            pending_r    <= pending_nxt;
            irq_on_r     <= irq_on_nxt;
        end
    end

    // bus answer, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_r <= 16'h0000;
            ack_r   <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            ack_r   <= reg_rd || reg_wr;
        end
    end

    // correction field out, one cycle latency
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            corr_r       <= 64'h0;
            corr_valid_r <= 1'b0;
        end else begin
            corr_r       <= corr_in.valid ? corr_adj : corr_r; // [R2] [R3]
            corr_valid_r <= corr_in.valid;
        end
    end

    // port interrupt summary, taken from next state to avoid an extra cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_status_r <= 1'b0;
            irq_enable_r <= 1'b0;
        end else begin
            irq_status_r <= |pending_nxt; // [R10]
            irq_enable_r <= |irq_on_nxt;  // [R12]
        end
    end

    // *****************************************
    // outputs
    // *****************************************
    assign reg_rdata             = rdata_r;
    assign reg_ack               = ack_r;
    assign corr_out              = corr_r;
    assign corr_out_valid        = corr_valid_r;
    assign port_stamp_irq_status = irq_status_r;
    assign port_stamp_irq_enable = irq_enable_r;
    assign asym_sign             = asym_r[PTPTS_BIT_SIGN];
    assign asym_magnitude        = asym_r[PTPTS_MAG_W-1:0];

endmodule

// ===== verif/ptpts_port_regs_properties.sv
module ptpts_regs_chk
    import ptpts_pkg::*;
(
    // clock, reset and register port
    input wire logic         clk,
    input wire logic         rst_b,
    input wire logic [11:0]  reg_addr,
    input wire logic         reg_wr,
    input wire logic         reg_rd,
    input wire logic [1:0]   reg_be,
    input wire logic [15:0]  reg_wdata,
    input wire logic [15:0]  reg_rdata,
    input wire logic         reg_ack,
    // datapath and port level bits
    input wire ptpts_stamp_s stamp_in,
    input wire ptpts_corr_s  corr_in,
    input wire logic [63:0]  corr_out,
    input wire logic         corr_out_valid,
    input wire logic         port_stamp_irq_status,
    input wire logic         port_stamp_irq_enable,
    input wire logic         asym_sign,
    input wire logic [14:0]  asym_magnitude
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ****************************************
    // decodes, offset bit 0 ignored like the design
    // ****************************************
    wire logic        wr_ok   = reg_wr && !reg_rd;
    wire logic        wr_asym = wr_ok && reg_addr[11:1] == PTPTS_OFS_ASYM[11:1];
    wire logic        wr_stat = wr_ok && reg_addr[11:1] == PTPTS_OFS_STATUS[11:1];
    wire logic        wr_en   = wr_ok && reg_addr[11:1] == PTPTS_OFS_ENABLE[11:1];
    wire logic [63:0] mag_sh  = {33'h0, asym_magnitude, 16'h0};
    // signed shift of the asymmetry, wraps modulo 2^64
    wire logic [63:0] d_sig   = asym_sign ? 64'h0 - mag_sh : mag_sh;

    // ****************************************
    // named steps
    // ****************************************
    sequence s_rd_flags;
        reg_rd && (reg_addr[11:1] == PTPTS_OFS_STATUS[11:1]
                   || reg_addr[11:1] == PTPTS_OFS_ENABLE[11:1]);
    endsequence
    sequence s_take_add;
        corr_in.valid && !corr_in.egress && corr_in.kind inside {PTPTS_MSG_SYNC, PTPTS_MSG_RESP};
    endsequence
    sequence s_take_sub;
        corr_in.valid && corr_in.egress && corr_in.kind == PTPTS_MSG_REQ;
    endsequence

    a_sign_write:
        assert property (wr_asym && reg_be[1] |=> asym_sign == $past(reg_wdata[15]))
        else $error("sign bit not taken from write");
    a_mag_write:
        assert property (wr_asym && reg_be == 2'b11 |=> asym_magnitude == $past(reg_wdata[14:0]))
        else $error("magnitude not taken from write");
    a_corr_adds:
        assert property (s_take_add |=> corr_out_valid && corr_out == $past(corr_in.field)
                         + $past(d_sig)) else $error("ingress correction not added");
    a_corr_subtracts:
        assert property (s_take_sub |=> corr_out_valid && corr_out == $past(corr_in.field)
                         - $past(d_sig)) else $error("egress correction not subtracted");
    a_stamp_sets_flag:
        assert property (stamp_in.valid && stamp_in.kind != PTPTS_MSG_OTHER
                         |=> port_stamp_irq_status) else $error("stamp did not raise status");
    a_status_holds:
        assert property (port_stamp_irq_status && !wr_stat |=> port_stamp_irq_status)
        else $error("status dropped without a clear");
    a_status_cause:
        assert property ($rose(port_stamp_irq_status) |-> $past(stamp_in.valid))
        else $error("status rose without a stamp");
    a_full_clear:
        assert property (wr_stat && reg_be[1] && reg_wdata[15:13] == 3'b111 && !stamp_in.valid
                         |=> !port_stamp_irq_status) else $error("write one did not clear");
    a_enable_or:
        assert property (wr_en && reg_be[1]
                         |=> port_stamp_irq_enable == |$past(reg_wdata[15:13]))
        else $error("enable summary wrong");
    a_enable_stable:
        assert property (!(wr_en && reg_be[1]) |=> $stable(port_stamp_irq_enable))
        else $error("enable changed without a write");
    a_reserved_zero:
        assert property (s_rd_flags |=> reg_ack && reg_rdata[12:0] == 13'h0)
        else $error("reserved bits not zero");
endmodule

bind ptpts_port_regs ptpts_regs_chk ptpts_regs_chk_inst (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .stamp_in(stamp_in), .corr_in(corr_in), .corr_out(corr_out),
    .corr_out_valid(corr_out_valid), .port_stamp_irq_status(port_stamp_irq_status),
    .port_stamp_irq_enable(port_stamp_irq_enable), .asym_sign(asym_sign),
    .asym_magnitude(asym_magnitude));

// ===== verif/testbench.sv
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("FAIL t=%0t %s got %h exp %h", $time, msg, got, exp); end end

module testbench
    import ptpts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk, rst_b, reg_wr, reg_rd, reg_ack, corr_out_valid, asym_sign;
    logic         port_stamp_irq_status, port_stamp_irq_enable;
    logic [1:0]   reg_be;
    logic [11:0]  reg_addr;
    logic [14:0]  asym_magnitude;
    logic [15:0]  reg_wdata, reg_rdata, rd_val;
    logic [63:0]  corr_out;
    ptpts_stamp_s stamp_in;
    ptpts_corr_s  corr_in;
    int           mismatches = 0;
    int           total_checks = 0;

    // free running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ptpts_port_regs ptpts_port_regs_inst (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .stamp_in(stamp_in), .corr_in(corr_in), .corr_out(corr_out),
        .corr_out_valid(corr_out_valid), .port_stamp_irq_status(port_stamp_irq_status),
        .port_stamp_irq_enable(port_stamp_irq_enable), .asym_sign(asym_sign),
        .asym_magnitude(asym_magnitude));

    // ****************************************
    // drivers: one strobe cycle, sampled once the answer has settled
    // ****************************************
    task automatic reg_access(input logic wr, input logic [11:0] a, input logic [15:0] d,
                              input logic [1:0] be);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_be = be;
        reg_wr = wr;
        reg_rd = !wr;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rd_val = reg_rdata;
    endtask

    // released value is inverted so stale data cannot look right
    task automatic send_stamp(input ptpts_msg_e k, input logic [31:0] ns);
        @(negedge clk);
        stamp_in = '{1'b1, k, ns};
        @(negedge clk);
        stamp_in = '{1'b0, k, ~ns};
    endtask

    task automatic send_corr(input logic eg, input ptpts_msg_e k, input logic [63:0] f);
        @(negedge clk);
        corr_in = '{1'b1, eg, k, f};
        @(negedge clk);
        corr_in = '{1'b0, eg, k, ~f};
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_reset_values();
        for (int i = 0; i < 10; i++) begin
            reg_access(1'b0, 12'hc04 + 12'(i * 2), 16'h0, 2'b00);
            `CHK(rd_val, 16'h0000, "reset value")
            `CHK(reg_ack, 1'b1, "ack")
        end
        `CHK({port_stamp_irq_status, port_stamp_irq_enable}, 2'b00, "reset summary")
        $display("test_reset_values done");
    endtask

    task automatic test_asym();
        logic [63:0] f;
        logic [63:0] d;
        f = 64'h0123_4567_89ab_0000;
        d = 64'h0 - 64'h00ff_0000;
        reg_access(1'b1, PTPTS_OFS_ASYM, 16'h8005, 2'b11);
        reg_access(1'b0, PTPTS_OFS_ASYM, 16'h0, 2'b00);
        `CHK(rd_val, 16'h8005, "asym readback")
        // odd offset and low lane only: the sign must survive
        reg_access(1'b1, PTPTS_OFS_ASYM | 12'h1, 16'h7fff, 2'b01);
        `CHK({asym_sign, asym_magnitude}, 16'h80ff, "asym outputs")
        send_corr(1'b0, PTPTS_MSG_SYNC, f);
        `CHK(corr_out_valid, 1'b1, "corr valid")
        `CHK(corr_out, f + d, "ingress sync")
        send_corr(1'b0, PTPTS_MSG_RESP, f);
        `CHK(corr_out, f + d, "ingress resp")
        send_corr(1'b1, PTPTS_MSG_REQ, f);
        `CHK(corr_out, f - d, "egress req")
        send_corr(1'b0, PTPTS_MSG_REQ, f);
        `CHK(corr_out, f, "ingress req")
        send_corr(1'b1, PTPTS_MSG_SYNC, f);
        `CHK(corr_out, f, "egress sync")
        send_corr(1'b1, PTPTS_MSG_OTHER, f);
        `CHK(corr_out, f, "other kind")
        reg_access(1'b1, PTPTS_OFS_ASYM, 16'h0003, 2'b11);
        send_corr(1'b1, PTPTS_MSG_REQ, f);
        `CHK(corr_out, f - 64'h3_0000, "positive egress")
        $display("test_asym done");
    endtask

    task automatic test_stamps();
        ptpts_msg_e  kinds [3] = '{PTPTS_MSG_SYNC, PTPTS_MSG_REQ, PTPTS_MSG_RESP};
        logic [11:0] hi [3] = '{PTPTS_OFS_SYNC_HI, PTPTS_OFS_REQ_HI, PTPTS_OFS_RESP_HI};
        logic [31:0] ns;
        for (int i = 0; i < 3; i++) begin
            ns = 32'h8765_4321 ^ 32'(i * 32'h0101_1111);
            send_stamp(kinds[i], ns);
            `CHK(port_stamp_irq_status, 1'b1, "status summary")
            reg_access(1'b1, hi[i], 16'hffff, 2'b11);
            reg_access(1'b0, hi[i], 16'h0, 2'b00);
            `CHK(rd_val, ns[31:16], "stamp high")
            reg_access(1'b0, hi[i] + 12'h2, 16'h0, 2'b00);
            `CHK(rd_val, ns[15:0], "stamp low")
            reg_access(1'b0, PTPTS_OFS_STATUS, 16'h0, 2'b00);
            `CHK(rd_val, 16'h8000 >> i, "pending bit")
            reg_access(1'b1, PTPTS_OFS_STATUS, 16'h1fff, 2'b11);
            `CHK(port_stamp_irq_status, 1'b1, "no clear by zero")
            reg_access(1'b1, PTPTS_OFS_STATUS, 16'h8000 >> i, 2'b11);
            `CHK(port_stamp_irq_status, 1'b0, "cleared")
        end
        send_stamp(PTPTS_MSG_OTHER, 32'h1);
        foreach (kinds[i]) send_stamp(kinds[i], 32'h0);
        reg_access(1'b1, PTPTS_OFS_STATUS, 16'h8000, 2'b11);
        reg_access(1'b0, PTPTS_OFS_STATUS, 16'h0, 2'b00);
        `CHK(rd_val, 16'h6000, "others still pending")
        `CHK(port_stamp_irq_status, 1'b1, "or of rest")
        // all three ones written, the sync bit is already clear
        reg_access(1'b1, PTPTS_OFS_STATUS, 16'he000, 2'b11);
        `CHK(port_stamp_irq_status, 1'b0, "all clear")
        $display("test_stamps done");
    endtask

    task automatic test_enable();
        reg_access(1'b1, PTPTS_OFS_ENABLE, 16'hffff, 2'b11);
        reg_access(1'b0, PTPTS_OFS_ENABLE, 16'h0, 2'b00);
        `CHK(rd_val, 16'he000, "enable readback")
        reg_access(1'b1, PTPTS_OFS_ENABLE, 16'h2000, 2'b10);
        reg_access(1'b1, PTPTS_OFS_ENABLE, 16'hffff, 2'b01);
        reg_access(1'b0, PTPTS_OFS_ENABLE, 16'h0, 2'b00);
        `CHK(rd_val, 16'h2000, "single enable")
        `CHK(port_stamp_irq_enable, 1'b1, "enable summary")
        reg_access(1'b1, PTPTS_OFS_ENABLE, 16'h0000, 2'b11);
        `CHK(port_stamp_irq_enable, 1'b0, "enable off")
        $display("test_enable done");
    endtask

    // reset in mid run must drop captured stamps, flags and enables
    task automatic test_mid_reset();
        send_stamp(PTPTS_MSG_SYNC, 32'h5a5a_a5a5);
        reg_access(1'b1, PTPTS_OFS_ENABLE, 16'he000, 2'b11);
        @(negedge clk);
        rst_b = 1'b0;
        @(negedge clk);
        rst_b = 1'b1;
        `CHK({port_stamp_irq_status, port_stamp_irq_enable}, 2'b00, "mid summary")
        reg_access(1'b0, PTPTS_OFS_SYNC_HI, 16'h0, 2'b00);
        `CHK(rd_val, 16'h0000, "sync stamp after reset")
        reg_access(1'b0, PTPTS_OFS_STATUS, 16'h0, 2'b00);
        `CHK(rd_val, 16'h0000, "status after reset")
        $display("test_mid_reset done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        finish_test();
    end

    // main sequence
    initial begin
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_be = 2'b00;
        reg_addr = 12'h0;
        reg_wdata = 16'h0;
        stamp_in = '0;
        corr_in = '0;
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        test_reset_values();
        test_asym();
        test_stamps();
        test_enable();
        test_mid_reset();
        finish_test();
    end
endmodule
